// ---- core/dwbl_pkg.sv ----
// Package: constants and carrier types for the DDR word byte lane block
package dwbl_pkg;
  localparam int WORD_W = 16;
  localparam int BYTE_W = 8;
  localparam int HI_MSB = 15;
  localparam int HI_LSB = 8;
  localparam int LO_MSB = 7;
  localparam int LO_LSB = 0;
  localparam int FIFO_DEPTH = 8;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [15:0] WORD_RST = 16'h0000;

  // Word captured from the link, with per-byte keep flags
  typedef struct packed {
    logic [WORD_W-1:0] data;
    logic keep_hi;
    logic keep_lo;
  } dwbl_wr_t;

  // Pin group for the 8-bit bus and the read_write_data_strobe
  typedef struct packed {
    logic [BYTE_W-1:0] dq;
    logic dq_oe;
    logic strobe;
    logic strobe_oe;
  } dwbl_pins_t;
endpackage

// ---- core/dwbl_fifo.sv ----
// Synchronous valid/ready FIFO with parameter width and depth
`timescale 1ns/1ps
module dwbl_fifo #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] CNT_FULL = (AW+1)'(DEPTH);
  localparam logic [AW-1:0] PTR_LAST = AW'(DEPTH - 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;

  wire do_push = in_valid && in_ready;
  wire do_pop = out_valid && out_ready;
  wire [AW-1:0] next_wr_ptr = (wr_ptr == PTR_LAST) ? '0 : wr_ptr + 1'b1;
  wire [AW-1:0] next_rd_ptr = (rd_ptr == PTR_LAST) ? '0 : rd_ptr + 1'b1;

  assign in_ready = (count != CNT_FULL);
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];

  always_ff @(posedge clk) begin
    if (do_push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (do_push) wr_ptr <= next_wr_ptr;
      if (do_pop) rd_ptr <= next_rd_ptr;
      if (do_push && !do_pop) count <= count + 1'b1;
      else if (do_pop && !do_push) count <= count - 1'b1;
    end
  end

  chk_fifo_no_overflow: assert property (@(posedge clk) disable iff (!rst_n)
    count <= CNT_FULL)
    else $error("fifo accepts data while full");
endmodule

// ---- core/dwbl_lane.sv ----
// Byte lane placement of 16-bit words on the 8-bit DDR data bus
`timescale 1ns/1ps
// Operation
// R1 - Each read clock cycle moves two bytes of one word, one per strobe half. Here a cycle with rd_valid low moves no byte.
// R2 - Read upper byte is driven from strobe rise to strobe fall, edge aligned.
// R3 - Read lower byte is driven from strobe fall to the next strobe rise.
// R4 - Write upper byte taken at clock rise, lower byte at clock fall.
// R5 - Register space is big-endian: first byte carries word bits 15 to 8.
// R6 - First byte holds bits 15..8, second bits 7..0, each on lines 7..0.
// R7 - Host centres write data on the sampling clock edge.
// R8 - Writes with latency use the strobe as a per-byte mask.
// R9 - Zero-latency writes carry no mask; full words are stored.
// R10 - During zero-latency write data the device holds the strobe low.
// R11 - Strobe high masks the byte, array unchanged; low stores it.
// R12 - Host drives strobe low as mask preamble before latency ends.
// R13 - Memory bytes return in the same positions they were written.
module dwbl_lane
  import dwbl_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic link_ck,
  input wire logic link_cs_n,
  input wire logic [BYTE_W-1:0] dq_in,
  input wire logic strobe_in,
  output dwbl_pins_t pins,
  input wire logic rd_phase,
  input wire logic wr_phase,
  input wire logic wr_zero_lat,
  input wire logic reg_space,
  input wire logic rd_valid,
  output logic rd_ready,
  input wire logic [WORD_W-1:0] rd_word,
  output logic wr_valid,
  input wire logic wr_ready,
  output dwbl_wr_t wr_word,
  output logic wr_fifo_ready
);
  // Two-flop synchronisers for all pin inputs
  logic ck_s1, ck_s2, ck_d;
  logic cs_s1, cs_s2;
  logic [BYTE_W-1:0] dq_s1, dq_s2;
  logic st_s1, st_s2;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ck_s1 <= 1'b0;
      ck_s2 <= 1'b0;
      ck_d <= 1'b0;
      cs_s1 <= 1'b1;
      cs_s2 <= 1'b1;
      dq_s1 <= BYTE_RST;
      dq_s2 <= BYTE_RST;
      st_s1 <= 1'b0;
      st_s2 <= 1'b0;
    end else begin
      ck_s1 <= link_ck;
      ck_s2 <= ck_s1;
      ck_d <= ck_s2;
      cs_s1 <= link_cs_n;
      cs_s2 <= cs_s1;
      dq_s1 <= dq_in;
      dq_s2 <= dq_s1;
      st_s1 <= strobe_in;
      st_s2 <= st_s1;
    end
  end

  wire ck_rise = ck_s2 && !ck_d;
  wire ck_fall = !ck_s2 && ck_d;
  wire selected = !cs_s2;
  wire rd_act = selected && rd_phase;
  wire wr_act = selected && wr_phase;
  wire mask_on = !wr_zero_lat;

  // Write capture: upper byte at rise, lower byte and push at fall
  logic [BYTE_W-1:0] hi_byte;
  logic hi_keep;
  logic have_hi;
  dwbl_wr_t wr_in;
  wire wr_push = wr_act && ck_fall && have_hi;

  assign wr_in.data = {hi_byte, dq_s2}; // see R6
  assign wr_in.keep_hi = hi_keep;
  assign wr_in.keep_lo = mask_on && st_s2; // see R8, R9, R11

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      hi_byte <= BYTE_RST;
      hi_keep <= 1'b0;
      have_hi <= 1'b0;
    end else if (wr_act && ck_rise) begin
      hi_byte <= dq_s2; // see R4
      hi_keep <= mask_on && st_s2; // see R8
      have_hi <= 1'b1;
    end else if (!wr_act || ck_fall) begin
      have_hi <= 1'b0;
    end
  end

  dwbl_fifo #(
    .WIDTH($bits(dwbl_wr_t)),
    .DEPTH(DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(wr_push),
    .in_ready(wr_fifo_ready),
    .in_data(wr_in),
    .out_valid(wr_valid),
    .out_ready(wr_ready),
    .out_data(wr_word)
  );

  // Read drive: upper byte with strobe high, lower byte with strobe low
  logic [BYTE_W-1:0] lo_hold;
  logic sending;
  dwbl_pins_t next_pins;
  wire rd_go = rd_act && ck_rise && rd_valid;
  wire rd_lo = rd_act && ck_fall && sending;
  wire zl_write = wr_act && wr_zero_lat;

  assign rd_ready = rd_go; // see R1

  always_comb begin
    next_pins = pins;
    next_pins.dq_oe = rd_act;
    next_pins.strobe_oe = rd_act || zl_write;
    if (rd_go) begin
      next_pins.dq = rd_word[HI_MSB:HI_LSB]; // see R2, R5, R13
      next_pins.strobe = 1'b1;
    end else if (rd_lo) begin
      next_pins.dq = lo_hold; // see R3
      next_pins.strobe = 1'b0;
    end else if (!rd_act) begin
      next_pins.strobe = 1'b0; // see R10
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pins <= '0;
      lo_hold <= BYTE_RST;
      sending <= 1'b0;
    end else begin
      pins <= next_pins;
      if (rd_go) lo_hold <= rd_word[LO_MSB:LO_LSB];
      if (rd_go) sending <= 1'b1;
      else if (rd_lo || !rd_act) sending <= 1'b0;
    end
  end

  chk_read_upper_byte: assert property (@(posedge clk) disable iff (!rst_n) // see R2
    rd_go |=> pins.dq == $past(rd_word[HI_MSB:HI_LSB]) && pins.strobe)
    else $error("upper read byte not driven with strobe high");

  chk_read_lower_byte: assert property (@(posedge clk) disable iff (!rst_n) // see R3
    rd_lo |=> !pins.strobe && pins.dq == $past(lo_hold))
    else $error("lower read byte not driven with strobe low");

  chk_one_word_cycle: assert property (@(posedge clk) disable iff (!rst_n) // see R1
    rd_go |=> sending && pins.dq_oe)
    else $error("read word not started");

  chk_reg_big_endian: assert property (@(posedge clk) disable iff (!rst_n) // see R5
    rd_go && reg_space |=> pins.dq == $past(rd_word[HI_MSB:HI_LSB]))
    else $error("register read not big-endian");

  chk_write_pairing: assert property (@(posedge clk) disable iff (!rst_n) // see R4
    wr_act && ck_rise |=> have_hi && hi_byte == $past(dq_s2))
    else $error("write upper byte not taken at clock rise");

  chk_zero_lat_full: assert property (@(posedge clk) disable iff (!rst_n) // see R9
    wr_push && wr_zero_lat |-> !wr_in.keep_hi && !wr_in.keep_lo)
    else $error("zero latency write masked a byte");

  chk_mask_honour: assert property (@(posedge clk) disable iff (!rst_n) // see R11
    wr_push && !wr_zero_lat |-> wr_in.keep_lo == st_s2)
    else $error("write mask not honoured");

  chk_zl_strobe_low: assert property (@(posedge clk) disable iff (!rst_n) // see R10
    zl_write && !rd_act |=> pins.strobe_oe && !pins.strobe)
    else $error("strobe not held low in zero latency write");
endmodule

// ---- tb/dwbl_host.sv ----
// Host link master model: clock, select, data and mask
`timescale 1ns/1ps
module dwbl_host
  import dwbl_pkg::*;
(
  input wire dwbl_pins_t pins,
  output logic ck,
  output logic cs_n,
  output logic [7:0] dq,
  output logic ds,
  output logic ds_en
);
  initial {ck, cs_n, dq, ds, ds_en} = 12'h400;
  task automatic open(input logic en);
    cs_n = 0;
    ds = 0;
    ds_en = en;
    #80;
  endtask
  task automatic close();
    #40 cs_n = 1;
    ds_en = 0;
    dq = ~dq;
    #40;
  endtask
  // Each byte centred on its sampling edge
  task automatic wr(input logic [15:0] w, input logic [1:0] m);
    dq = w[15:8];
    ds = m[1];
    #40 ck = 1;
    #40 dq = w[7:0];
    ds = m[0];
    #40 ck = 0;
    #40;
  endtask
  task automatic rd(output logic [9:0] a, output logic [9:0] b);
    ck = 1;
    #70 a = {pins.dq_oe, pins.strobe, pins.dq};
    #10 ck = 0;
    #70 b = {pins.dq_oe, pins.strobe, pins.dq};
    #10;
  endtask
endmodule

// ---- tb/dwbl_lane_test.sv ----
// Self-checking bench: host model, queue model, lane block
`timescale 1ns/1ps
module dwbl_lane_test;
  import dwbl_pkg::*;
  logic clk = 0, rst_n = 0, rd_phase = 0, wr_phase = 0, zl = 0, rs = 0;
  logic rd_valid = 0, wr_ready = 0, stall = 0, ck, cs_n, h_ds, h_en;
  logic rd_ready, wr_valid, wr_fifo_ready;
  logic [15:0] rd_word = 16'h0000, w;
  logic [7:0] h_dq;
  logic [9:0] a, b;
  logic [17:0] q[$];
  dwbl_pins_t pins;
  dwbl_wr_t wr_word;
  int n_fail = 0, checks_done = 0;
  int n_take = 0;
  logic take;
  wire [7:0] dq_in = pins.dq_oe ? pins.dq : h_dq;
  wire ds_in = pins.strobe_oe ? pins.strobe : (h_en ? h_ds : ~h_ds);
  dwbl_host host_u (.pins(pins), .ck(ck), .cs_n(cs_n), .dq(h_dq),
    .ds(h_ds), .ds_en(h_en));
  dwbl_lane dut_u (.clk(clk), .rst_n(rst_n), .link_ck(ck),
    .link_cs_n(cs_n), .dq_in(dq_in), .strobe_in(ds_in), .pins(pins),
    .rd_phase(rd_phase), .wr_phase(wr_phase), .wr_zero_lat(zl),
    .reg_space(rs), .rd_valid(rd_valid), .rd_ready(rd_ready),
    .rd_word(rd_word), .wr_valid(wr_valid), .wr_ready(wr_ready),
    .wr_word(wr_word), .wr_fifo_ready(wr_fifo_ready));
  initial forever #5 clk = ~clk;
  task automatic cmp_bus(input logic [15:0] g, e);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %0t bus %h exp %h", $time, g, e);
    end
  endtask
  task automatic cmp_word(input logic [17:0] g, e);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %0t word %h exp %h", $time, g, e);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d fails %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Consumer with random stalls
  always @(negedge clk) begin
    take = !stall && ($urandom % 4 != 0);
    if (wr_valid === 1'b1 && take)
      cmp_word(wr_word, q.size() ? q.pop_front() : 18'h0);
    wr_ready <= take;
  end
  // Counts words the device takes for reading
  always @(negedge clk) begin
    if (rd_ready === 1'b1) n_take++;
  end
  task automatic wr_words(input int n, input logic z);
    @(negedge clk);
    zl = z;
    wr_phase = 1;
    host_u.open(!z);
    for (int i = 0; i < n; i++) begin
      w = $urandom;
      if (q.size() < FIFO_DEPTH)
        q.push_back({w, z ? 2'b00 : i[1:0]});
      host_u.wr(w, i[1:0]);
      if (z) cmp_bus({pins.strobe_oe, pins.strobe}, 2);
    end
    host_u.close();
    wr_phase = 0;
  endtask
  task automatic rd_words(input logic r);
    int t0;
    @(negedge clk);
    t0 = n_take;
    rs = r;
    rd_phase = 1;
    host_u.open(0);
    for (int i = 0; i < 4; i++) begin
      rd_word = $urandom;
      rd_valid = i != 2;
      host_u.rd(a, b);
      cmp_bus(a[9:8], {1'b1, rd_valid});
      cmp_bus(b[9:8], 2'b10);
      if (rd_valid) cmp_bus({a[7:0], b[7:0]}, rd_word);
    end
    cmp_bus(n_take - t0, 3);
    host_u.close();
    rd_phase = 0;
  endtask
  initial begin
    void'($urandom(10));
    repeat (20) @(negedge clk);
    cmp_bus({pins, wr_valid, wr_fifo_ready}, 16'h0001);
    rst_n = 1;
    @(negedge clk);
    wr_words(8, 0);
    $display("done masked writes");
    wr_words(8, 1);
    $display("done zero latency writes");
    stall = 1;
    wr_words(FIFO_DEPTH + 1, 0);
    cmp_bus(wr_fifo_ready, 0);
    stall = 0;
    for (int k = 0; k < 400 && q.size() > 0; k++) @(negedge clk);
    repeat (4) @(negedge clk);
    cmp_bus({q.size() != 0, wr_valid}, 0);
    $display("done fifo fill and drain");
    rd_words(0);
    rd_words(1);
    $display("done reads");
    print_verdict();
  end
  initial begin
    #200000;
    n_fail++;
    print_verdict();
  end
endmodule
